/* logic/spi_status_core.sv */
// Serial shift engine with transmit/receive buffers and buffer-status flags
// Assumes pins arrive unsynchronised; mode 0 timing (sample on rising SCK)
//
// How it works
// - In slave role the shift-empty flag sets once a word is done, no transmit word waits and nothing waits for the receive buffer.
// - The shift-empty flag clears when a transmit word loads into the shifter or a slave SCK edge starts shifting.
// - In master role the shift-empty flag reads 1 always.
// - In slave role the receive-empty flag is 1 when the receive buffer holds no unread word.
// - The receive-empty flag is 0 while an unread received word waits.
// - In master role the receive-empty flag reads 1 always.
// - As slave, MOSI is sampled in the middle of each bit, on the synchronised rising SCK edge.
// - As master, MISO is sampled one system clock before the bit period ends.
// - The master-enable input selects slave (0) or master (1) that drives SCK.
// - The busy flag is 1 while a transfer runs in either role.
`timescale 1ns/1ns
module spi_status_core #(
  parameter int unsigned WORD_W  = spi_status_pkg::WORD_BITS,
  parameter int unsigned TX_DEPTH = spi_status_pkg::FIFO_DEPTH
) (
  // Clock, reset, enable
  input  wire logic              I_CLK_SYS,
  input  wire logic              I_RST,
  input  wire logic              I_CE,
  // Control
  input  wire logic              I_MASTER_ROLE_ENABLE,
  // Transmit side
  input  wire logic              I_TX_VALID,
  output logic                   O_TX_READY,
  input  wire logic [WORD_W-1:0] I_TX_DATA,
  // Receive buffer read
  input  wire logic              I_RX_READ,
  output logic      [WORD_W-1:0] O_RX_DATA,
  // Status
  output logic                   O_SHIFT_REG_EMPTY_FLAG,
  output logic                   O_RX_BUFFER_EMPTY_FLAG,
  output logic                   O_TRANSFER_BUSY_FLAG,
  // Serial pins
  input  wire logic              I_SCK,
  input  wire logic              I_NSS_N,
  input  wire logic              I_MOSI,
  input  wire logic              I_MISO,
  output logic                   O_SCK,
  output logic                   O_SCK_OE,
  output logic                   O_MOSI,
  output logic                   O_MISO,
  output logic                   O_MISO_OE
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [3:0] pins_sync;

  sync_two_ff #(
    .WIDTH (4)
  ) u_sync (
    .clk (I_CLK_SYS),
    .rst (I_RST),
    .ce  (I_CE),
    .d   ({I_SCK, !I_NSS_N, I_MOSI, I_MISO}),
    .q   (pins_sync)
  );

  wire sck_s  = pins_sync[3];
  // Select is synchronised active high so that reset reads as deselected
  wire nss_s  = !pins_sync[2];
  wire mosi_s = pins_sync[1];
  wire miso_s = pins_sync[0];

  logic sck_d;
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      sck_d <= 1'h0;
    end else if (I_CE) begin
      sck_d <= sck_s;
    end
  end

  wire master    = I_MASTER_ROLE_ENABLE;
  wire selected  = !master && !nss_s;
  wire sck_rise  = selected && sck_s && !sck_d;
  wire sck_fall  = selected && !sck_s && sck_d;

  // ****************************************************************
  // Transmit buffer
  // ****************************************************************
  logic              tx_valid;
  logic              tx_pop;
  logic [WORD_W-1:0] tx_word;

  word_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (TX_DEPTH)
  ) u_tx_fifo (
    .clk       (I_CLK_SYS),
    .rst       (I_RST),
    .ce        (I_CE),
    .in_valid  (I_TX_VALID),
    .in_ready  (O_TX_READY),
    .in_data   (I_TX_DATA),
    .out_valid (tx_valid),
    .out_ready (tx_pop),
    .out_data  (tx_word)
  );

  // ****************************************************************
  // Shift engine state
  // ****************************************************************
  localparam int unsigned HALF = spi_status_pkg::SCK_HALF_CYC;
  localparam int unsigned CW   = $clog2(HALF + 1);

  spi_status_pkg::master_state_t state;
  spi_status_pkg::master_state_t next_state;

  logic [WORD_W-1:0]                   shifter;
  logic [spi_status_pkg::CNT_BITS-1:0] bit_cnt;
  logic [CW-1:0]                       div_cnt;
  logic                                active;
  logic                                loaded;
  logic                                miso_bit;
  logic                                rx_full;
  logic [WORD_W-1:0]                   rx_buf;
  logic                                rx_pending;

  wire last_bit    = (bit_cnt == spi_status_pkg::CNT_BITS'(WORD_W - 1));
  wire div_end     = (div_cnt == CW'(HALF - 1));
  wire div_sample  = (div_cnt == CW'(HALF - 1 - spi_status_pkg::MISO_EARLY_CYC));
  wire m_start     = master && (state == spi_status_pkg::ST_IDLE) && tx_valid;
  wire s_load      = !master && !active && !loaded && tx_valid;
  wire s_done      = sck_fall && active && last_bit;
  wire m_done      = master && (state == spi_status_pkg::ST_SECOND) && div_end && last_bit;
  wire word_done   = s_done || m_done;
  wire slave_start = sck_rise && !active;

  assign tx_pop = I_CE && (m_start || s_load);

  always_comb begin
    next_state = state;
    case (state)
      spi_status_pkg::ST_IDLE: begin
        if (m_start) begin
          next_state = spi_status_pkg::ST_FIRST;
        end
      end
      spi_status_pkg::ST_FIRST: begin
        if (div_end) begin
          next_state = spi_status_pkg::ST_SECOND;
        end
      end
      spi_status_pkg::ST_SECOND: begin
        if (div_end) begin
          next_state = last_bit ? spi_status_pkg::ST_IDLE : spi_status_pkg::ST_FIRST;
        end
      end
      default: begin
        next_state = spi_status_pkg::ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // Master half-period divider and state
  // ****************************************************************
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST || !master) begin
      state   <= spi_status_pkg::ST_IDLE;
      div_cnt <= '0;
    end else if (I_CE) begin
      state <= next_state;
      if (state == spi_status_pkg::ST_IDLE || div_end) begin
        div_cnt <= '0;
      end else begin
        div_cnt <= div_cnt + 1'b1;
      end
    end
  end

  // ****************************************************************
  // Shift register
  // ****************************************************************
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      shifter  <= spi_status_pkg::WORD_RST;
      bit_cnt  <= '0;
      active   <= 1'h0;
      loaded   <= 1'h0;
      miso_bit <= 1'h0;
    end else if (I_CE) begin
      if (m_start || s_load) begin
        shifter <= tx_word;
        bit_cnt <= '0;
        loaded  <= 1'h1;
        active  <= master;
      end
      if (master && state == spi_status_pkg::ST_SECOND && div_sample) begin
        miso_bit <= miso_s;
      end
      if (master && state == spi_status_pkg::ST_SECOND && div_end) begin
        shifter <= {shifter[WORD_W-2:0], miso_bit};
        bit_cnt <= bit_cnt + 1'b1;
        if (last_bit) begin
          active <= 1'h0;
          loaded <= 1'h0;
        end
      end
      if (sck_rise) begin
        miso_bit <= mosi_s;
        active   <= 1'h1;
      end
      if (sck_fall && active) begin
        shifter <= {shifter[WORD_W-2:0], miso_bit};
        bit_cnt <= bit_cnt + 1'b1;
        if (last_bit) begin
          active  <= 1'h0;
          loaded  <= 1'h0;
          bit_cnt <= '0;
        end
      end
      if (!master && nss_s && !sck_rise) begin
        active  <= 1'h0;
        bit_cnt <= '0;
      end
    end
  end

  // ****************************************************************
  // Receive buffer
  // ****************************************************************
  wire [WORD_W-1:0] done_word = {shifter[WORD_W-2:0], miso_bit};

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      rx_buf     <= spi_status_pkg::WORD_RST;
      rx_full    <= 1'h0;
      rx_pending <= 1'h0;
    end else if (I_CE) begin
      rx_pending <= 1'h0;
      if (word_done) begin
        rx_buf     <= done_word;
        rx_full    <= 1'h1;
        rx_pending <= 1'h1;
      end else if (I_RX_READ) begin
        rx_full <= 1'h0;
      end
    end
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  wire shift_empty_slave = !active && !loaded && !tx_valid && !rx_pending && !slave_start;
  wire next_shift_empty  = master ? 1'h1 : shift_empty_slave;
  wire next_rx_empty     = master ? 1'h1 : !rx_full;
  wire next_busy         = active || (master && state != spi_status_pkg::ST_IDLE) || m_start;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      O_SHIFT_REG_EMPTY_FLAG <= spi_status_pkg::SHIFT_EMPTY_RST;
      O_RX_BUFFER_EMPTY_FLAG <= spi_status_pkg::RX_EMPTY_RST;
      O_TRANSFER_BUSY_FLAG   <= spi_status_pkg::BUSY_RST;
      O_RX_DATA              <= spi_status_pkg::WORD_RST;
      O_SCK                  <= 1'h0;
      O_SCK_OE               <= 1'h0;
      O_MOSI                 <= 1'h0;
      O_MISO                 <= 1'h0;
      O_MISO_OE              <= 1'h0;
    end else if (I_CE) begin
      O_SHIFT_REG_EMPTY_FLAG <= next_shift_empty;
      O_RX_BUFFER_EMPTY_FLAG <= next_rx_empty;
      O_TRANSFER_BUSY_FLAG   <= next_busy;
      O_RX_DATA              <= rx_buf;
      O_SCK                  <= master && (next_state == spi_status_pkg::ST_SECOND);
      O_SCK_OE               <= master;
      O_MOSI                 <= master ? shifter[WORD_W-1] : 1'h0;
      O_MISO                 <= shifter[WORD_W-1];
      O_MISO_OE              <= selected;
    end
  end

endmodule : spi_status_core

/* logic/spi_status_pkg.sv */
// Constants and types shared by the serial buffer-status block
// Assumes a 100 MHz system clock and an 8-bit serial word
package spi_status_pkg;

  // ****************************************************************
  // Widths and depths
  // ****************************************************************
  localparam int unsigned WORD_BITS   = 8;
  localparam int unsigned FIFO_DEPTH  = 8;
  localparam int unsigned CNT_BITS    = 4;

  // ****************************************************************
  // Status field positions
  // ****************************************************************
  localparam int unsigned RX_EMPTY_POS    = 0;
  localparam int unsigned SHIFT_EMPTY_POS = 1;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic       SHIFT_EMPTY_RST = 1'h1;
  localparam logic       RX_EMPTY_RST    = 1'h1;
  localparam logic       BUSY_RST        = 1'h0;
  localparam logic [7:0] WORD_RST        = 8'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned SCK_HALF_NS    = 80;
  localparam int unsigned SCK_HALF_CYC   = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MISO_EARLY_CYC = 1;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FIRST,
    ST_SECOND
  } master_state_t;

endpackage : spi_status_pkg

/* logic/sync_two_ff.sv */
// Two-flip-flop synchroniser for inputs from outside the clock domain
// Assumes the enable freezes state like the rest of the block
`timescale 1ns/1ns
module sync_two_ff #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else if (ce) begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : sync_two_ff

/* logic/word_fifo.sv */
// Synchronous word FIFO with valid and ready on both sides
// Assumes a single clock and clock enable
`timescale 1ns/1ns
module word_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;

  wire do_push = ce && in_valid && in_ready;
  wire do_pop  = ce && out_valid && out_ready;
  wire [AW-1:0] wr_inc = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
  wire [AW-1:0] rd_inc = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;

  assign in_ready  = (count != (AW + 1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_inc;
      end
      if (do_pop) begin
        rd_ptr <= rd_inc;
      end
      if (do_push && !do_pop) begin
        count <= count + 1'b1;
      end else if (do_pop && !do_push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule : word_fifo

/* testbench/spi_status_assertions.sv */
// Port checker of the serial buffer-status block
// Assumes it is bound to spi_status_core with the clock enable held high
`timescale 1ns/1ns
module spi_status_assertions (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic I_MASTER_ROLE_ENABLE,
  input wire logic I_TX_VALID,
  input wire logic O_TX_READY,
  input wire logic I_RX_READ,
  input wire logic I_NSS_N,
  input wire logic O_SHIFT_REG_EMPTY_FLAG,
  input wire logic O_RX_BUFFER_EMPTY_FLAG,
  input wire logic O_TRANSFER_BUSY_FLAG,
  input wire logic O_SCK,
  input wire logic O_SCK_OE,
  input wire logic O_MISO_OE
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);
  wire m  = I_MASTER_ROLE_ENABLE;
  wire se = O_SHIFT_REG_EMPTY_FLAG;
  wire re = O_RX_BUFFER_EMPTY_FLAG;
  wire bz = O_TRANSFER_BUSY_FLAG;
  wire push = I_TX_VALID && O_TX_READY;
  property p_se_master; m && $past(m) |-> se; endproperty
  property p_re_master; m && $past(m) |-> re; endproperty
  property p_re_hold; !re && !I_RX_READ && !$past(I_RX_READ) && !m |=> !re || m; endproperty
  property p_re_read; I_RX_READ && !m && I_NSS_N && $past(I_NSS_N, 4) |=> ##[0:2] re; endproperty
  property p_se_load; !m && I_NSS_N && push && se |-> ##[1:4] !se; endproperty
  property p_sck_high; $rose(O_SCK) |=> O_SCK [*7] ##1 !O_SCK; endproperty
  property p_sck_busy; O_SCK |-> bz; endproperty
  property p_busy_master; m && $past(m) && push && !bz |-> ##[1:6] bz; endproperty
  property p_oe_role; !$past(I_RST) && $stable(m) |-> O_SCK_OE == m; endproperty
  property p_miso_oe; O_MISO_OE |-> !$past(m); endproperty
  a_se_master: assert property (p_se_master) else $error("shift empty low in master role");
  a_re_master: assert property (p_re_master) else $error("rx empty low in master role");
  a_re_hold: assert property (p_re_hold) else $error("rx empty rose without a read");
  a_re_read: assert property (p_re_read) else $error("rx empty not set after read");
  a_se_load: assert property (p_se_load) else $error("shift empty not cleared by load");
  a_sck_high: assert property (p_sck_high) else $error("sck high half not 8 cycles");
  a_sck_busy: assert property (p_sck_busy) else $error("sck high while not busy");
  a_busy_master: assert property (p_busy_master) else $error("busy not raised");
  a_oe_role: assert property (p_oe_role) else $error("sck enable disagrees with role");
  a_miso_oe: assert property (p_miso_oe) else $error("miso driven in master role");
  c_rx_word: cover property ($fell(re));
  c_sck: cover property ($rose(O_SCK));
  c_full: cover property (!O_TX_READY);
endmodule : spi_status_assertions

bind spi_status_core spi_status_assertions i_spi_status_assertions (
  .I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_MASTER_ROLE_ENABLE(I_MASTER_ROLE_ENABLE),
  .I_TX_VALID(I_TX_VALID), .O_TX_READY(O_TX_READY), .I_RX_READ(I_RX_READ), .I_NSS_N(I_NSS_N),
  .O_SHIFT_REG_EMPTY_FLAG(O_SHIFT_REG_EMPTY_FLAG), .O_RX_BUFFER_EMPTY_FLAG(O_RX_BUFFER_EMPTY_FLAG),
  .O_TRANSFER_BUSY_FLAG(O_TRANSFER_BUSY_FLAG), .O_SCK(O_SCK), .O_SCK_OE(O_SCK_OE), .O_MISO_OE(O_MISO_OE));

/* testbench/spi_far_end.sv */
// Far-side serial model: a master for slave role, a slave for master role
// Assumes mode 0 and an 80 ns half bit
`timescale 1ns/1ns
module spi_far_end (
  input  wire logic i_sck,
  input  wire logic i_mosi,
  input  wire logic i_miso,
  output logic      o_sck,
  output logic      o_nss_n,
  output logic      o_mosi,
  output logic      o_miso
);
  logic [7:0] sl_sh;
  logic [7:0] sl_got;
  initial begin
    o_sck = 1'h0;
    o_nss_n = 1'h1;
    o_mosi = 1'h0;
    o_miso = 1'h0;
    sl_sh = 8'h00;
    sl_got = 8'h00;
  end
  // ****
  // Slave side: capture on rise, next bit on fall
  // ****
  always @(posedge i_sck) sl_got = {sl_got[6:0], i_mosi};
  always @(negedge i_sck) begin
    sl_sh = {sl_sh[6:0], ~sl_sh[0]};
    o_miso = sl_sh[7];
  end
  task automatic load(input logic [7:0] w);
    sl_sh = w;
    sl_got = 8'h00;
    o_miso = w[7];
  endtask : load
  // ****
  // Master side: one framed word, MSB first
  // ****
  task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
    #3 o_nss_n = 1'h0;
    #80;
    for (int i = 7; i >= 0; i--) begin
      o_mosi = tx[i];
      #80 o_sck = 1'h1;
      rx = {rx[6:0], i_miso};
      #80 o_sck = 1'h0;
    end
    #80 o_nss_n = 1'h1;
    o_mosi = ~o_mosi;
  endtask : frame
endmodule : spi_far_end

/* testbench/testbench.sv */
// Self-checking bench of the serial buffer-status block
// Assumes the far-side model spi_far_end and the bound checker
`timescale 1ns/1ns
`define CHK(s, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s exp %h got %h", s, e, g); end end
module testbench;
  logic       clk = 1'h0;
  logic       rst;
  logic       master;
  logic       tx_valid;
  logic [7:0] tx_data;
  logic       rx_read;
  logic       tx_ready, se, re, bz, sck_o, sck_oe, mosi_o, miso_o, miso_oe;
  logic       f_sck, f_nss_n, f_mosi, f_miso;
  logic [7:0] rx_data;
  int         fail_count = 0;
  int         n_tests = 0;
  wire        sck_w = sck_oe ? sck_o : f_sck;
  wire        miso_w = miso_oe ? miso_o : clk;
  always #5 clk = ~clk;
  spi_status_core i_spi_status_core (
    .I_CLK_SYS(clk), .I_RST(rst), .I_CE(1'h1), .I_MASTER_ROLE_ENABLE(master),
    .I_TX_VALID(tx_valid), .O_TX_READY(tx_ready), .I_TX_DATA(tx_data),
    .I_RX_READ(rx_read), .O_RX_DATA(rx_data), .O_SHIFT_REG_EMPTY_FLAG(se),
    .O_RX_BUFFER_EMPTY_FLAG(re), .O_TRANSFER_BUSY_FLAG(bz), .I_SCK(sck_w), .I_NSS_N(f_nss_n),
    .I_MOSI(f_mosi), .I_MISO(f_miso), .O_SCK(sck_o), .O_SCK_OE(sck_oe), .O_MOSI(mosi_o),
    .O_MISO(miso_o), .O_MISO_OE(miso_oe));
  spi_far_end i_spi_far_end (
    .i_sck(sck_w), .i_mosi(mosi_o), .i_miso(miso_w), .o_sck(f_sck), .o_nss_n(f_nss_n),
    .o_mosi(f_mosi), .o_miso(f_miso));
  // ****
  // Helpers
  // ****
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic push(input logic [7:0] d);
    tx_valid = 1'h1;
    tx_data = d;
    tick(1);
    tx_valid = 1'h0;
  endtask : push
  task automatic rd;
    rx_read = 1'h1;
    tick(1);
    rx_read = 1'h0;
    tick(3);
  endtask : rd
  task automatic wait_bz(input logic v);
    for (int n = 0; n < 400 && bz !== v; n++) tick(1);
  endtask : wait_bz
  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    `CHK("shift empty", 1'h1, se)
    `CHK("rx empty", 1'h1, re)
    `CHK("busy", 1'h0, bz)
    $display("test reset done");
  endtask : t_reset
  task automatic t_slave;
    logic [7:0] got;
    push(8'hA5);
    tick(4);
    `CHK("shift empty load", 1'h0, se)
    fork
      i_spi_far_end.frame(8'h3C, got);
      begin #700; `CHK("busy slave", 1'h1, bz) end
    join
    tick(6);
    `CHK("miso word", 8'hA5, got)
    `CHK("rx data slave", 8'h3C, rx_data)
    `CHK("rx empty unread", 1'h0, re)
    `CHK("shift empty done", 1'h1, se)
    rd;
    `CHK("rx empty read", 1'h1, re)
    $display("test slave done");
  endtask : t_slave
  task automatic t_master;
    master = 1'h1;
    i_spi_far_end.load(8'h96);
    tick(3);
    `CHK("shift empty master", 1'h1, se)
    push(8'h5A);
    wait_bz(1'h1);
    `CHK("busy master", 1'h1, bz)
    wait_bz(1'h0);
    tick(3);
    `CHK("rx data master", 8'h96, rx_data)
    `CHK("mosi word", 8'h5A, i_spi_far_end.sl_got)
    `CHK("rx empty master", 1'h1, re)
    `CHK("shift empty after", 1'h1, se)
    master = 1'h0;
    tick(3);
    $display("test master done");
  endtask : t_master
  task automatic t_fifo;
    int n;
    logic [7:0] got;
    n = 0;
    tx_valid = 1'h1;
    while (tx_ready === 1'h1 && n < 12) begin
      tx_data = 8'h10 + n[7:0];
      tick(1);
      n++;
    end
    tx_valid = 1'h0;
    `CHK("words taken", spi_status_pkg::FIFO_DEPTH + 1, n)
    `CHK("shift empty waiting", 1'h0, se)
    for (int k = 0; k < n; k++) begin
      i_spi_far_end.frame(8'hC0 + k[7:0], got);
      tick(6);
      `CHK("fifo word", 8'h10 + k[7:0], got)
      `CHK("fifo rx data", 8'hC0 + k[7:0], rx_data)
      rd;
    end
    `CHK("shift empty drained", 1'h1, se)
    `CHK("ready drained", 1'h1, tx_ready)
    $display("test fifo done");
  endtask : t_fifo
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  initial begin
    rst = 1'h1;
    master = 1'h0;
    tx_valid = 1'h0;
    tx_data = 8'h00;
    rx_read = 1'h0;
    tick(2);
    rst = 1'h0;
    tick(1);
    t_reset;
    t_slave;
    t_master;
    t_fifo;
    summarize;
  end
  initial begin
    #100000;
    fail_count++;
    summarize;
  end
endmodule : testbench
